/* core/acc_ctrl.sv */
// converter conversion control with ahb-lite register slave
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module acc_ctrl #(
    parameter int TRIG_W = 23
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [TRIG_W-1:0] TRIG_SRC,
    input wire logic TRIG_PIN,
    input wire logic SLEEP,
    input wire logic [9:0] SAMPLE_DATA,
    output logic SAMPLE_EN,
    output logic CONV_ACTIVE,
    output logic WAKE,
    output logic VECTOR_IRQ
);
    logic [6:0] ctrl_q;
    logic [5:0] div_q;
    logic [4:0] trig_sel_q;
    logic [5:0] chan_q;
    logic [9:0] res_q;
    logic [9:0] prev_q;
    logic [15:0] acc_q;
    logic [10:0] err_q;
    logic [9:0] thr_q;
    logic [3:0] stat_q;
    logic [2:0] ie_q;
    logic powered_q;
    logic dsen_phase_q;
    logic math_pend_q;
    acc_pkg::acc_state_t state_q;
    logic [4:0] half_cnt_q;
    logic [2:0] dly_q;
    logic [2:0] pin_sync_q;
    logic pin_lvl_q;
    logic [TRIG_W-1:0] src_q;
    logic trig_lvl_q;
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic half_tick;
    logic trig_lvl;
    logic trig_edge;
    logic sw_evt;
    logic complete;
    logic ctrl_wr;
    logic [31:0] rd_word;

    // ----------------------------------------------------------------
    // bus slave: address phase capture, zero wait state answers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (HREADY) begin
            wr_q <= HSEL && HTRANS[1] && HWRITE;
            rd_q <= HSEL && HTRANS[1] && !HWRITE;
            addr_q <= HADDR[7:0];
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // read mux decodes the address phase so the word stands in the data phase
    always_comb begin
        if (HADDR[7:0] == acc_pkg::CTRL_OFS) begin
            rd_word = {25'h0, ctrl_q};
        end else if (HADDR[7:0] == acc_pkg::CLK_OFS) begin
            rd_word = {26'h0, div_q};
        end else if (HADDR[7:0] == acc_pkg::TRIG_OFS) begin
            rd_word = {27'h0, trig_sel_q};
        end else if (HADDR[7:0] == acc_pkg::CHAN_OFS) begin
            rd_word = {26'h0, chan_q};
        end else if (HADDR[7:0] == acc_pkg::RES_OFS) begin
            rd_word = ctrl_q[acc_pkg::CTRL_JUST] ? {22'h0, res_q}
                                                  : {16'h0, res_q, 6'h00};
        end else if (HADDR[7:0] == acc_pkg::PREV_OFS) begin
            rd_word = {22'h0, prev_q};
        end else if (HADDR[7:0] == acc_pkg::ACC_OFS) begin
            rd_word = {16'h0, acc_q};
        end else if (HADDR[7:0] == acc_pkg::ERR_OFS) begin
            rd_word = {21'h0, err_q};
        end else if (HADDR[7:0] == acc_pkg::THR_OFS) begin
            rd_word = {22'h0, thr_q};
        end else if (HADDR[7:0] == acc_pkg::STAT_OFS) begin
            rd_word = {28'h0, stat_q};
        end else if (HADDR[7:0] == acc_pkg::IRQ_OFS) begin
            rd_word = {29'h0, ie_q};
        end else begin
            rd_word = acc_pkg::ZERO_RST;
        end
    end

    // loaded at the accepted read's address phase, held until the next read
    always_ff @(posedge CLK) begin
        if (RST) begin
            HRDATA <= acc_pkg::ZERO_RST;
        end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
            HRDATA <= rd_word;
        end
    end

    // ----------------------------------------------------------------
    // plain configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_q <= 6'h00;
            trig_sel_q <= acc_pkg::TRG_OFF;
            chan_q <= 6'h00;
            thr_q <= 10'h000;
            ie_q <= 3'h0;
        end else if (wr_q) begin
            if (addr_q == acc_pkg::CLK_OFS) begin
                div_q <= HWDATA[5:0];
            end else if (addr_q == acc_pkg::TRIG_OFS) begin
                trig_sel_q <= HWDATA[4:0];
            end else if (addr_q == acc_pkg::CHAN_OFS) begin
                chan_q <= HWDATA[5:0];
            end else if (addr_q == acc_pkg::THR_OFS) begin
                thr_q <= HWDATA[9:0];
            end else if (addr_q == acc_pkg::IRQ_OFS) begin
                ie_q <= HWDATA[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // trigger selection and edge detection
    // ----------------------------------------------------------------
    // pin is asynchronous: three stages, a change counts when 2 and 3 agree
    always_ff @(posedge CLK) begin
        if (RST) begin
            pin_sync_q <= 3'h0;
            pin_lvl_q <= 1'b0;
            src_q <= '0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], TRIG_PIN};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
            src_q <= TRIG_SRC;
        end
    end

    // software events are pulses, hardware sources are levels
    always_comb begin
        trig_lvl = 1'b0;
        sw_evt = 1'b0;
        if (trig_sel_q == acc_pkg::TRG_PIN) begin
            trig_lvl = pin_lvl_q;
        end else if (trig_sel_q >= 5'h02 && trig_sel_q <= acc_pkg::TRG_IOC) begin
            trig_lvl = src_q[trig_sel_q - 5'h01];
        end else if (trig_sel_q == acc_pkg::TRG_CHAN) begin
            sw_evt = wr_q && (addr_q == acc_pkg::CHAN_OFS);
        end else if (trig_sel_q == acc_pkg::TRG_RESH) begin
            sw_evt = rd_q && (addr_q == acc_pkg::RES_OFS);
        end else if (trig_sel_q == acc_pkg::TRG_ERRH) begin
            sw_evt = rd_q && (addr_q == acc_pkg::ERR_OFS);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            trig_lvl_q <= 1'b0;
        end else begin
            trig_lvl_q <= trig_lvl;
        end
    end

    assign trig_edge = (trig_lvl && !trig_lvl_q) || sw_evt;

    // ----------------------------------------------------------------
    // control register and go bit
    // ----------------------------------------------------------------
    assign ctrl_wr = wr_q && (addr_q == acc_pkg::CTRL_OFS);
    assign complete = (state_q == acc_pkg::ACC_CONV) && half_tick
                      && (half_cnt_q == 5'(acc_pkg::HALF_TAD_TOTAL - 1));

    // hardware set of go wins over a software write in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q <= 7'h00;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= HWDATA[6:0];
            end else if (complete && !ctrl_q[acc_pkg::CTRL_CONT]) begin
                ctrl_q[acc_pkg::CTRL_GO] <= 1'b0;
            end
            if (ctrl_q[acc_pkg::CTRL_ON] && trig_edge
                && !(SLEEP && !ctrl_q[acc_pkg::CTRL_CS])) begin
                ctrl_q[acc_pkg::CTRL_GO] <= 1'b1;
            end else if (stat_q[acc_pkg::ST_PEND] && !SLEEP && ctrl_q[acc_pkg::CTRL_ON]) begin
                ctrl_q[acc_pkg::CTRL_GO] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    acc_clkgen u_clkgen (
        .CLK(CLK),
        .RST(RST),
        .run(state_q == acc_pkg::ACC_CONV),
        .rc_sel(ctrl_q[acc_pkg::CTRL_CS]),
        .div_sel(div_q),
        .half_tick(half_tick)
    );

    // system clock stops in sleep, so only the rc clock keeps converting
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= acc_pkg::ACC_IDLE;
            half_cnt_q <= 5'h00;
            dly_q <= 3'h0;
        end else if (!ctrl_q[acc_pkg::CTRL_GO] || !ctrl_q[acc_pkg::CTRL_ON]
                     || (SLEEP && !ctrl_q[acc_pkg::CTRL_CS])) begin
            state_q <= acc_pkg::ACC_IDLE;
            half_cnt_q <= 5'h00;
        end else begin
            case (state_q)
                acc_pkg::ACC_IDLE: begin
                    half_cnt_q <= 5'h00;
                    dly_q <= 3'(acc_pkg::INSTR_CYCLES - 1);
                    state_q <= ctrl_q[acc_pkg::CTRL_CS] ? acc_pkg::ACC_DELAY
                                                         : acc_pkg::ACC_CONV;
                end
                acc_pkg::ACC_DELAY: begin
                    dly_q <= dly_q - 3'h1;
                    if (dly_q == 3'h0) begin
                        state_q <= acc_pkg::ACC_CONV;
                    end
                end
                acc_pkg::ACC_CONV: begin
                    if (half_tick) begin
                        half_cnt_q <= half_cnt_q + 5'h01;
                        if (complete) begin
                            half_cnt_q <= 5'h00;
                            state_q <= acc_pkg::ACC_IDLE;
                        end
                    end
                end
                default: state_q <= acc_pkg::ACC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // result, previous, accumulator, error
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            res_q <= 10'h000;
            prev_q <= 10'h000;
            acc_q <= 16'h0000;
            dsen_phase_q <= 1'b0;
            math_pend_q <= 1'b0;
            err_q <= 11'h000;
        end else begin
            math_pend_q <= 1'b0;
            if (complete) begin
                if (!ctrl_q[acc_pkg::CTRL_PSIS]) begin
                    prev_q <= res_q;
                end
                res_q <= SAMPLE_DATA;
                acc_q <= acc_q + {6'h00, SAMPLE_DATA};
                dsen_phase_q <= ctrl_q[acc_pkg::CTRL_DSEN] ? !dsen_phase_q : 1'b0;
                math_pend_q <= !ctrl_q[acc_pkg::CTRL_DSEN] || dsen_phase_q;
            end
            if (math_pend_q) begin
                err_q <= {1'b0, res_q} - {1'b0, thr_q};
            end
        end
    end

    // ----------------------------------------------------------------
    // status flags: hardware set beats software clear
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            stat_q <= 4'h0;
        end else begin
            if (wr_q && addr_q == acc_pkg::STAT_OFS) begin
                stat_q <= stat_q & ~HWDATA[3:0];
            end
            if (complete) begin
                stat_q[acc_pkg::ST_DONE] <= 1'b1;
                stat_q[acc_pkg::ST_MATH] <= 1'b1;
            end
            if (math_pend_q && !err_q[10] && (res_q >= thr_q)) begin
                stat_q[acc_pkg::ST_THR] <= 1'b1;
            end
            if (ctrl_q[acc_pkg::CTRL_ON] && trig_edge && SLEEP && !ctrl_q[acc_pkg::CTRL_CS]) begin
                stat_q[acc_pkg::ST_PEND] <= 1'b1;
            end else if (!SLEEP && stat_q[acc_pkg::ST_PEND]) begin
                stat_q[acc_pkg::ST_PEND] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // power, wake and vector outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            powered_q <= 1'b0;
        end else if (complete && SLEEP && !ie_q[acc_pkg::IE_CONV]) begin
            powered_q <= 1'b0;
        end else if (!SLEEP || ctrl_wr) begin
            powered_q <= ctrl_q[acc_pkg::CTRL_ON];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            WAKE <= 1'b0;
            VECTOR_IRQ <= 1'b0;
        end else begin
            WAKE <= SLEEP && stat_q[acc_pkg::ST_DONE] && ie_q[acc_pkg::IE_CONV];
            VECTOR_IRQ <= stat_q[acc_pkg::ST_DONE] && (&ie_q);
        end
    end

    assign SAMPLE_EN = powered_q;
    assign CONV_ACTIVE = (state_q == acc_pkg::ACC_CONV);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    done_sticky_a: assert property (@(posedge CLK) disable iff (RST)
        stat_q[0] && !(wr_q && addr_q == acc_pkg::STAT_OFS) |=> stat_q[0])
        else $error("done flag dropped without a clear");
    done_on_end_a: assert property (@(posedge CLK) disable iff (RST)
        complete |=> stat_q[0] && stat_q[1])
        else $error("done flag not set at completion");
    go_clear_a: assert property (@(posedge CLK) disable iff (RST)
        complete && !ctrl_q[2] && !ctrl_wr && !trig_edge |=> !ctrl_q[1])
        else $error("go not cleared after completion");
    result_load_a: assert property (@(posedge CLK) disable iff (RST)
        complete |=> res_q == $past(SAMPLE_DATA))
        else $error("result not loaded");
    abort_keep_a: assert property (@(posedge CLK) disable iff (RST)
        state_q == acc_pkg::ACC_CONV && !ctrl_q[1] |=> state_q == acc_pkg::ACC_IDLE
        && $stable(res_q))
        else $error("abort did not hold result");
    rc_delay_a: assert property (@(posedge CLK) disable iff (RST)
        state_q == acc_pkg::ACC_IDLE ##1 state_q == acc_pkg::ACC_DELAY
        |-> (state_q == acc_pkg::ACC_DELAY)[*3])
        else $error("rc start delay too short");
    pend_sleep_a: assert property (@(posedge CLK) disable iff (RST)
        SLEEP && !ctrl_q[4] |-> state_q != acc_pkg::ACC_CONV ##1 1)
        else $error("system clock conversion ran in sleep");
    trig_go_a: assert property (@(posedge CLK) disable iff (RST)
        ctrl_q[0] && trig_edge && !SLEEP |=> ctrl_q[1])
        else $error("trigger edge did not set go");
endmodule : acc_ctrl

/* core/acc_pkg.sv */
// package of constants and types for the converter conversion control block
package acc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CLK_OFS = 8'h04;
    localparam logic [7:0] TRIG_OFS = 8'h08;
    localparam logic [7:0] CHAN_OFS = 8'h0c;
    localparam logic [7:0] RES_OFS = 8'h10;
    localparam logic [7:0] PREV_OFS = 8'h14;
    localparam logic [7:0] ACC_OFS = 8'h18;
    localparam logic [7:0] ERR_OFS = 8'h1c;
    localparam logic [7:0] THR_OFS = 8'h20;
    localparam logic [7:0] STAT_OFS = 8'h24;
    localparam logic [7:0] IRQ_OFS = 8'h28;
    // control register bit positions
    localparam int CTRL_ON = 0;
    localparam int CTRL_GO = 1;
    localparam int CTRL_CONT = 2;
    localparam int CTRL_JUST = 3;
    localparam int CTRL_CS = 4;
    localparam int CTRL_PSIS = 5;
    localparam int CTRL_DSEN = 6;
    // status bit positions (write one to clear)
    localparam int ST_DONE = 0;
    localparam int ST_MATH = 1;
    localparam int ST_THR = 2;
    localparam int ST_PEND = 3;
    // irq enable register bit positions
    localparam int IE_CONV = 0;
    localparam int IE_PERI = 1;
    localparam int IE_GLOB = 2;
    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam int HALF_TAD_TOTAL = 23;          // 11.5 periods in half periods
    localparam int RC_HALF_CYCLES = 20;          // rc half period in system clocks
    localparam int INSTR_CYCLES = 4;             // one instruction cycle
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    // trigger select encodings
    localparam logic [4:0] TRG_OFF = 5'h00;
    localparam logic [4:0] TRG_PIN = 5'h01;
    localparam logic [4:0] TRG_IOC = 5'h17;
    localparam logic [4:0] TRG_ERRH = 5'h1c;
    localparam logic [4:0] TRG_RESH = 5'h1d;
    localparam logic [4:0] TRG_CHAN = 5'h1f;
    localparam int TRG_SRC_N = 23;               // hardware sources 1 to 23
    typedef enum logic [1:0] {ACC_IDLE, ACC_DELAY, ACC_CONV} acc_state_t;
endpackage : acc_pkg

/* core/acc_clkgen.sv */
// converter clock generator: half period enable from divider or rc source
`timescale 1ns/1ps
module acc_clkgen (
    input wire logic CLK,
    input wire logic RST,
    input wire logic run,
    input wire logic rc_sel,
    input wire logic [5:0] div_sel,
    output logic half_tick
);
    logic [7:0] cnt_q;
    logic [7:0] lim;

    // ----------------------------------------------------------------
    // half period length
    // ----------------------------------------------------------------
    // divide by 2*(n+1) means a half period of n+1 system clocks
    always_comb begin
        if (rc_sel) begin
            lim = 8'(acc_pkg::RC_HALF_CYCLES - 1);
        end else begin
            lim = {2'h0, div_sel};
        end
    end

    // counter restarts whenever no conversion runs, so phase is aligned
    always_ff @(posedge CLK) begin
        if (RST || !run) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= lim) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign half_tick = run && (cnt_q >= lim);
endmodule : acc_clkgen

/* bench/acc_partner.sv */
// partner model: hardware trigger sources and analog sampler
`timescale 1ns/1ps
module acc_partner (
    input wire logic clk,
    input wire logic sample_en,
    input wire logic [9:0] level,
    input wire logic [22:0] trig_req,
    output logic [22:0] trig_src,
    output logic trig_pin,
    output logic [9:0] sample_data
);
    logic [9:0] last_q = 10'h000;
    // triggers are levels in the system clock domain, one edge late
    always @(posedge clk) begin
        trig_src <= trig_req;
        if (sample_en) last_q <= level;
    end
    // unpowered sampler shows the inverse, so a stale capture cannot match
    assign sample_data = sample_en ? level : ~last_q;
    // request bit 0 stands for the pin source, which has no on-chip line
    assign trig_pin = trig_src[0];
endmodule : acc_partner

/* bench/testbench.sv */
// self-checking testbench for the conversion control block
`timescale 1ns/1ps
module testbench;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic SLEEP = 1'b0;
    logic [9:0] lvl = 10'h2a5;
    logic [22:0] trq = 23'h0;
    logic [22:0] tsrc;
    logic tpin;
    logic [9:0] sdata;
    logic [31:0] HRDATA;
    logic [31:0] rd;
    logic HREADYOUT, HRESP, SAMPLE_EN, CONV_ACTIVE, WAKE, VECTOR_IRQ;
    int mismatches = 0;
    int n_tests = 0;
    always #25 CLK = ~CLK;
    acc_ctrl DUT (.CLK(CLK), .RST(RST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TRIG_SRC(tsrc),
        .TRIG_PIN(tpin), .SLEEP(SLEEP), .SAMPLE_DATA(sdata), .SAMPLE_EN(SAMPLE_EN),
        .CONV_ACTIVE(CONV_ACTIVE), .WAKE(WAKE), .VECTOR_IRQ(VECTOR_IRQ));
    acc_partner far (.clk(CLK), .sample_en(SAMPLE_EN), .level(lvl), .trig_req(trq),
        .trig_src(tsrc), .trig_pin(tpin), .sample_data(sdata));
    // ----
    // bus and check helpers
    // ----
    task give_verdict;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // bounded wait for the slave's ready at a rising edge
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge CLK);
            i++;
        end while (HREADYOUT !== 1'b1 && i < 20);
        if (HREADYOUT !== 1'b1) begin
            mismatches++;
            give_verdict;
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        wait_rdy;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy;
        rd = HRDATA;
    endtask : xfer
    // poll status until done is seen; the limit is a hang guard only
    task automatic wait_done(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            xfer(1'b0, acc_pkg::STAT_OFS, 32'h0);
            if (rd[acc_pkg::ST_DONE] === 1'b1) break;
        end
        if (rd[acc_pkg::ST_DONE] !== 1'b1) begin
            mismatches++;
            give_verdict;
        end
    endtask : wait_done
    // software go, both justifications, previous copy and flag lifetime
    task t_basic;
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'h9); // go in a later write than on
        repeat (4) @(posedge CLK); // acquisition wait before go
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'hb);
        wait_done(60);
        chk("math", rd[1], 1'b1);
        chk("power", SAMPLE_EN, 1'b1);
        chk("vector", VECTOR_IRQ, 1'b0);
        xfer(1'b0, acc_pkg::RES_OFS, 32'h0);
        chk("right", rd, {22'h0, lvl});
        xfer(1'b0, acc_pkg::CTRL_OFS, 32'h0);
        chk("go", rd[1], 1'b0);
        xfer(1'b0, acc_pkg::STAT_OFS, 32'h0);
        chk("hold", rd[0], 1'b1);
        chk("thr", rd[2], 1'b1);
        xfer(1'b1, acc_pkg::STAT_OFS, 32'hf);
        lvl <= 10'h15a;
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'h3);
        wait_done(60);
        xfer(1'b0, acc_pkg::RES_OFS, 32'h0);
        chk("left", rd, {16'h0, 10'h15a, 6'h0});
        xfer(1'b0, acc_pkg::PREV_OFS, 32'h0);
        chk("prev", rd, 32'h2a5);
        xfer(1'b1, acc_pkg::STAT_OFS, 32'hf);
    endtask : t_basic
    // clearing go mid conversion keeps the old result
    task t_abort;
        lvl <= 10'h0f0;
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'h3);
        repeat (4) @(posedge CLK);
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'h1);
        repeat (60) @(posedge CLK);
        xfer(1'b0, acc_pkg::RES_OFS, 32'h0);
        chk("abort res", rd, {16'h0, 10'h15a, 6'h0});
        xfer(1'b0, acc_pkg::STAT_OFS, 32'h0);
        chk("abort done", rd[0], 1'b0);
    endtask : t_abort
    // every hardware source, then a sleep-held trigger and a software event
    task automatic t_trig;
        int k;
        for (k = 1; k <= 23; k++) begin
            xfer(1'b1, acc_pkg::TRIG_OFS, k);
            trq <= 23'h1 << (k - 1);
            xfer(1'b1, acc_pkg::STAT_OFS, 32'h0);
            trq <= 23'h0;
            wait_done(60);
            xfer(1'b1, acc_pkg::STAT_OFS, 32'hf);
        end
        SLEEP <= 1'b1;
        trq <= 23'h400000;
        xfer(1'b1, acc_pkg::STAT_OFS, 32'h0);
        trq <= 23'h0;
        repeat (60) @(posedge CLK);
        xfer(1'b0, acc_pkg::STAT_OFS, 32'h0);
        chk("held", rd[0], 1'b0);
        SLEEP <= 1'b0;
        wait_done(60);
        xfer(1'b1, acc_pkg::STAT_OFS, 32'hf);
        xfer(1'b1, acc_pkg::TRIG_OFS, 32'h1f);
        xfer(1'b1, acc_pkg::CHAN_OFS, 32'h3);
        wait_done(60);
        xfer(1'b1, acc_pkg::STAT_OFS, 32'hf);
    endtask : t_trig
    // rc clock conversion in sleep wakes; vectoring needs the global enable
    task t_sleep;
        xfer(1'b1, acc_pkg::TRIG_OFS, 32'h0);
        xfer(1'b1, acc_pkg::IRQ_OFS, 32'h3);
        SLEEP <= 1'b1;
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'h13); // rc clock for sleep work
        wait_done(400);
        repeat (2) @(posedge CLK);
        chk("wake", WAKE, 1'b1);
        chk("inline", VECTOR_IRQ, 1'b0);
        xfer(1'b1, acc_pkg::IRQ_OFS, 32'h7);
        repeat (2) @(posedge CLK);
        chk("vector", VECTOR_IRQ, 1'b1);
        xfer(1'b1, acc_pkg::STAT_OFS, 32'hf);
        xfer(1'b1, acc_pkg::IRQ_OFS, 32'h0);
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'h13);
        wait_done(400);
        chk("power down", SAMPLE_EN, 1'b0);
        xfer(1'b0, acc_pkg::CTRL_OFS, 32'h0);
        chk("on kept", rd[0], 1'b1);
        SLEEP <= 1'b0;
    endtask : t_sleep
    // reset right after the go write, before the sequencer leaves idle, turns the converter off
    task t_reset;
        xfer(1'b1, acc_pkg::CTRL_OFS, 32'h3);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        xfer(1'b0, acc_pkg::CTRL_OFS, 32'h0);
        chk("ctrl rst", rd, 32'h0);
        repeat (60) @(posedge CLK);
        xfer(1'b0, acc_pkg::STAT_OFS, 32'h0);
        chk("stat rst", rd, 32'h0);
    endtask : t_reset
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        t_basic;
        t_abort;
        t_trig;
        t_sleep;
        t_reset;
        give_verdict;
    end
endmodule : testbench
